// file: core/mic_edge_det.sv
// Purpose: edge or change detector over a group of input pins
// Assumes: pins synchronous to clock
// Notes: first cycle after reset only primes the history
`timescale 1ns/100ps
module mic_edge_det #(
    parameter int unsigned W = 1
) (
    input  wire logic              clock,
    input  wire logic              arst_n,
    input  wire logic [W-1:0]      pins,
    input  wire mic_pkg::mic_edge_t mode,
    output logic                   evt
);
    typedef struct packed {
        logic         primed;
        logic [W-1:0] prev;
    } mic_edst_t;

    mic_edst_t st_ff;
    mic_edst_t nxt_st;

    always_comb begin
        nxt_st        = st_ff;
        nxt_st.primed = 1'b1;
        nxt_st.prev   = pins;
    end

    // history is not primed yet, so a pin high at reset is no edge
    always_comb begin
        evt = 1'b0;
        if (st_ff.primed) begin
            case (mode)
                mic_pkg::MIC_EDGE_RISE: evt = |(pins & ~st_ff.prev);
                mic_pkg::MIC_EDGE_FALL: evt = |(~pins & st_ff.prev);
                mic_pkg::MIC_EDGE_ANY:  evt = |(pins ^ st_ff.prev);
                default:                evt = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule : mic_edge_det

// file: core/mic_intc.sv
// Purpose: interrupt controller of a small 8-bit core, apb register port
// Assumes: one instruction cycle is four clocks, core supplies return pc
// Notes: register writes take effect in the apb access phase
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module mic_intc #(
    parameter int unsigned NP    = mic_pkg::PERIPH_NUM,
    parameter int unsigned DEPTH = mic_pkg::STACK_NUM
) (
    input  wire logic                     clock,
    input  wire logic                     arst_n,
    // apb slave
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    // event sources
    input  wire logic                     ext_irq_pin,
    input  wire logic [3:0]               port_b_pins,
    input  wire logic                     timer_wrap,
    input  wire logic [NP-1:0]            periph_evt,
    // core side
    input  wire logic                     sleep_mode,
    input  wire logic                     ret_from_irq,
    input  wire logic [mic_pkg::PC_W-1:0] return_pc,
    output logic                          vector_take,
    output logic      [mic_pkg::PC_W-1:0] vector_pc,
    output logic      [mic_pkg::PC_W-1:0] resume_pc,
    output logic                          wake_up,
    output logic                          irq_out
);
    localparam int unsigned SP_W = $clog2(DEPTH);
    localparam int unsigned PC_W = mic_pkg::PC_W;
    localparam int unsigned CN   = mic_pkg::CTX_NUM;

    typedef struct packed {
        logic [7:0]                 ctrl;
        logic [7:0]                 option;
        logic [NP-1:0]              pen;
        logic [mic_pkg::ST_W-1:0]   st_en;
        mic_pkg::mic_qph_t          qph;
        logic [mic_pkg::LAT_STAGES-1:0] pipe;
        logic [DEPTH-1:0][PC_W-1:0] stk;
        logic [SP_W-1:0]            sp;
        logic [CN-1:0][7:0]         ctx;
        logic [31:0]                prdata;
        logic                       pslverr;
        logic                       take;
        logic [PC_W-1:0]            vpc;
        logic [PC_W-1:0]            rpc;
        logic                       wake;
    } mic_state_t;

    mic_state_t st_ff;
    mic_state_t nxt_st;

    logic                       ext_evt;
    logic                       port_evt;
    logic [NP-1:0]              pflag;
    logic [mic_pkg::ST_W-1:0]   stat;
    logic [mic_pkg::ST_W-1:0]   stat_set;
    logic                       wr_acc;
    logic                       setup;
    logic                       is_ctx;
    logic [3:0]                 ctx_idx;
    logic                       pending;
    logic                       boundary;
    logic                       taking;
    logic [7:0]                 ctrl_hw;
    logic [SP_W-1:0]            sp_dec;

    mic_edge_det #(
        .W (1)
    ) u_ext_edge (
        .clock  (clock),
        .arst_n (arst_n),
        .pins   (ext_irq_pin),
        .mode   (st_ff.option[mic_pkg::B_EDGE] ?
                 mic_pkg::MIC_EDGE_RISE : mic_pkg::MIC_EDGE_FALL),
        .evt    (ext_evt)
    );

    mic_edge_det #(
        .W (4)
    ) u_port_chg (
        .clock  (clock),
        .arst_n (arst_n),
        .pins   (port_b_pins),
        .mode   (mic_pkg::MIC_EDGE_ANY),
        .evt    (port_evt)
    );

    // peripheral flags kept apart from the control byte
    mic_sticky #(
        .W (NP)
    ) u_pflag (
        .clock   (clock),
        .arst_n  (arst_n),
        .set     (periph_evt),
        .wr_en   (wr_acc && paddr == mic_pkg::OFS_PFLAG),
        .wr_w1c  (1'b0),
        .wr_data (pwdata[NP-1:0]),
        .flags   (pflag)
    );

    mic_sticky #(
        .W (mic_pkg::ST_W)
    ) u_stat (
        .clock   (clock),
        .arst_n  (arst_n),
        .set     (stat_set),
        .wr_en   (wr_acc && paddr == mic_pkg::OFS_STCLR),
        .wr_w1c  (1'b1),
        .wr_data (pwdata[mic_pkg::ST_W-1:0]),
        .flags   (stat)
    );

    assign setup  = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    // bank bits [7:6] are ignored so every bank sees one copy
    assign is_ctx  = (paddr[11:8] == mic_pkg::CTX_PAGE);
    assign ctx_idx = paddr[5:2];

    // request: or of flag-and-enable terms, peripherals behind group bit
    always_comb begin
        pending = (st_ff.ctrl[mic_pkg::B_XIF] && st_ff.ctrl[mic_pkg::B_XIE])
            || (st_ff.ctrl[mic_pkg::B_TIF] && st_ff.ctrl[mic_pkg::B_TIE])
            || (st_ff.ctrl[mic_pkg::B_PCIF] && st_ff.ctrl[mic_pkg::B_PCIE])
            || (st_ff.ctrl[mic_pkg::B_GRP]
                && |(pflag & st_ff.pen));
    end

    assign boundary = (st_ff.qph == mic_pkg::MIC_Q4);
    // vector only at an instruction boundary after two sampled boundaries,
    // so latency is counted in instruction cycles, not instruction length
    assign taking = boundary && st_ff.pipe[mic_pkg::LAT_STAGES-1]
        && pending && st_ff.ctrl[mic_pkg::B_GEN]
        && !ret_from_irq;

    assign sp_dec = st_ff.sp - 1'b1;

    always_comb begin
        stat_set = '0;
        stat_set[mic_pkg::ST_TAKE] = taking;
        stat_set[mic_pkg::ST_WAKE] = sleep_mode && pending;
        stat_set[mic_pkg::ST_RET]  = ret_from_irq;
    end

    always_comb begin
        ctrl_hw = '0;
        ctrl_hw[mic_pkg::B_XIF]  = ext_evt;
        ctrl_hw[mic_pkg::B_TIF]  = timer_wrap;
        ctrl_hw[mic_pkg::B_PCIF] = port_evt;
    end

    always_comb begin
        nxt_st      = st_ff;
        nxt_st.take = 1'b0;

        // instruction phase counter
        case (st_ff.qph)
            mic_pkg::MIC_Q1: nxt_st.qph = mic_pkg::MIC_Q2;
            mic_pkg::MIC_Q2: nxt_st.qph = mic_pkg::MIC_Q3;
            mic_pkg::MIC_Q3: nxt_st.qph = mic_pkg::MIC_Q4;
            mic_pkg::MIC_Q4: nxt_st.qph = mic_pkg::MIC_Q1;
            default:         nxt_st.qph = mic_pkg::MIC_Q1;
        endcase

        if (boundary) begin
            nxt_st.pipe = {st_ff.pipe[mic_pkg::LAT_STAGES-2:0], pending};
        end

        // software writes in the access phase
        if (wr_acc) begin
            case (paddr)
                mic_pkg::OFS_CTRL:   nxt_st.ctrl   = pwdata[7:0];
                mic_pkg::OFS_OPTION: nxt_st.option = pwdata[7:0];
                mic_pkg::OFS_PEN:    nxt_st.pen    = pwdata[NP-1:0];
                mic_pkg::OFS_STEN:
                    nxt_st.st_en = pwdata[mic_pkg::ST_W-1:0];
                default: begin
                    if (is_ctx) begin
                        nxt_st.ctx[ctx_idx] = pwdata[7:0];
                    end
                end
            endcase
        end

        // a hardware event wins over a clearing write in the same cycle
        nxt_st.ctrl = nxt_st.ctrl | ctrl_hw;

        // return restores enable and pops the pc; wins over a new entry
        if (ret_from_irq) begin
            nxt_st.ctrl[mic_pkg::B_GEN] = 1'b1;
            nxt_st.sp  = sp_dec;
            nxt_st.rpc = st_ff.stk[sp_dec];
        end else if (taking) begin
            // only the pc is saved; w, status and page latch are software's
            nxt_st.ctrl[mic_pkg::B_GEN] = 1'b0;
            nxt_st.stk[st_ff.sp] = return_pc;
            nxt_st.sp   = st_ff.sp + 1'b1;
            nxt_st.vpc  = mic_pkg::VECTOR_PC;
            nxt_st.take = 1'b1;
            nxt_st.pipe = '0;
        end

        // wake needs only the source enable, plus the group bit for peripherals; vectoring still needs gie
        nxt_st.wake = sleep_mode && pending;

        // read data and error captured in the setup phase
        if (setup) begin
            nxt_st.prdata  = '0;
            nxt_st.pslverr = 1'b0;
            case (paddr)
                mic_pkg::OFS_CTRL:   nxt_st.prdata[7:0] = st_ff.ctrl;
                mic_pkg::OFS_OPTION: nxt_st.prdata[7:0] = st_ff.option;
                mic_pkg::OFS_PFLAG:  nxt_st.prdata[NP-1:0] = pflag;
                mic_pkg::OFS_PEN:    nxt_st.prdata[NP-1:0] = st_ff.pen;
                mic_pkg::OFS_STAT:
                    nxt_st.prdata[mic_pkg::ST_W-1:0] = stat;
                mic_pkg::OFS_STEN:
                    nxt_st.prdata[mic_pkg::ST_W-1:0] = st_ff.st_en;
                mic_pkg::OFS_STCLR:  nxt_st.prdata = '0;
                default: begin
                    if (is_ctx) begin
                        nxt_st.prdata[7:0] = st_ff.ctx[ctx_idx];
                    end else begin
                        nxt_st.pslverr = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_ff        <= '0;
            st_ff.ctrl   <= mic_pkg::CTRL_RST;
            st_ff.option <= mic_pkg::OPTION_RST;
            st_ff.qph    <= mic_pkg::MIC_Q1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // zero wait states: read data was prepared during setup
    assign pready      = 1'b1;
    assign prdata      = st_ff.prdata;
    assign pslverr     = st_ff.pslverr;
    assign vector_take = st_ff.take;
    assign vector_pc   = st_ff.vpc;
    assign resume_pc   = st_ff.rpc;
    assign wake_up     = st_ff.wake;
    assign irq_out     = |(stat & st_ff.st_en);

endmodule : mic_intc

// file: core/mic_pkg.sv
// Purpose: constants and types shared by the interrupt controller files
// Assumes: apb byte offsets, 32-bit data, registers in the low 8 bits, peripheral flag and enable in the low 9
// Notes: all offsets, bit positions and reset values live here
package mic_pkg;

    localparam int unsigned PERIPH_NUM = 9;
    localparam int unsigned PC_W       = 13;
    localparam int unsigned STACK_NUM  = 8;
    localparam int unsigned CTX_NUM    = 16;

    localparam logic [11:0] OFS_CTRL   = 12'h000;
    localparam logic [11:0] OFS_OPTION = 12'h004;
    localparam logic [11:0] OFS_PFLAG  = 12'h008;
    localparam logic [11:0] OFS_PEN    = 12'h00C;
    localparam logic [11:0] OFS_STAT   = 12'h010;
    localparam logic [11:0] OFS_STEN   = 12'h014;
    localparam logic [11:0] OFS_STCLR  = 12'h018;
    localparam logic [3:0]  CTX_PAGE   = 4'h1;

    localparam int unsigned B_GEN  = 7;
    localparam int unsigned B_GRP  = 6;
    localparam int unsigned B_TIE  = 5;
    localparam int unsigned B_XIE  = 4;
    localparam int unsigned B_PCIE = 3;
    localparam int unsigned B_TIF  = 2;
    localparam int unsigned B_XIF  = 1;
    localparam int unsigned B_PCIF = 0;
    localparam int unsigned B_EDGE = 6;

    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] OPTION_RST = 8'hFF;

    localparam logic [PC_W-1:0] VECTOR_PC = 13'h0004;

    localparam int unsigned ST_TAKE = 0;
    localparam int unsigned ST_WAKE = 1;
    localparam int unsigned ST_RET  = 2;
    localparam int unsigned ST_W    = 3;

    localparam int unsigned LAT_STAGES = 2;

    typedef enum logic [1:0] {
        MIC_EDGE_FALL = 2'b00,
        MIC_EDGE_RISE = 2'b01,
        MIC_EDGE_ANY  = 2'b10
    } mic_edge_t;

    typedef enum logic [1:0] {
        MIC_Q1 = 2'b00,
        MIC_Q2 = 2'b01,
        MIC_Q3 = 2'b10,
        MIC_Q4 = 2'b11
    } mic_qph_t;

endpackage : mic_pkg

// file: core/mic_sticky.sv
// Purpose: bank of sticky event flags with software write access
// Assumes: set pulses one cycle wide or longer
// Notes: hardware set always wins over a software clear in one cycle
`timescale 1ns/100ps
module mic_sticky #(
    parameter int unsigned W = 1
) (
    input  wire logic         clock,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] set,
    input  wire logic         wr_en,
    input  wire logic         wr_w1c,
    input  wire logic [W-1:0] wr_data,
    output logic      [W-1:0] flags
);
    typedef struct packed {
        logic [W-1:0] flags;
    } mic_stk_t;

    mic_stk_t st_ff;
    mic_stk_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (wr_en) begin
            nxt_st.flags = wr_w1c ? (st_ff.flags & ~wr_data) : wr_data;
        end
        nxt_st.flags = nxt_st.flags | set;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign flags = st_ff.flags;

endmodule : mic_sticky

// file: testbench/mic_core_model.sv
// Purpose: behavioural core sequencer facing the interrupt controller
// Assumes: one instruction is four clocks, pc stalls while asleep
// Notes: saved_pc is what the core expects the controller to push
`timescale 1ns/100ps
module mic_core_model (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        go_sleep,
    input  wire logic        go_ret,
    input  wire logic        vector_take,
    input  wire logic        wake_up,
    output logic             sleep_mode,
    output logic             ret_from_irq,
    output logic [12:0]      return_pc,
    output logic [12:0]      saved_pc
);
    logic [1:0]  tick_ff;
    logic [12:0] last_ff;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tick_ff      <= 2'h0;
            last_ff      <= 13'h0000;
            return_pc    <= 13'h0100;
            saved_pc     <= 13'h0000;
            sleep_mode   <= 1'b0;
            ret_from_irq <= 1'b0;
        end else begin
            tick_ff      <= tick_ff + 2'h1;
            last_ff      <= return_pc;
            ret_from_irq <= go_ret;
            if (tick_ff == 2'h3 && !sleep_mode)
                return_pc <= return_pc + 13'h0001;
            // the pushed pc is the one shown the cycle before the take
            if (vector_take)
                saved_pc <= last_ff;
            if (go_sleep)
                sleep_mode <= 1'b1;
            else if (wake_up)
                sleep_mode <= 1'b0;
        end
    end
endmodule : mic_core_model

// file: testbench/mic_intc_chk.sv
// Purpose: port checks for the interrupt controller
// Assumes: interrupts nest one deep at most
// Notes: global enable is mirrored from port traffic, phase from a clock count since reset
`timescale 1ns/100ps
module mic_intc_chk (
    input wire logic        clock,
    input wire logic        arst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pslverr,
    input wire logic        sleep_mode,
    input wire logic        ret_from_irq,
    input wire logic [12:0] return_pc,
    input wire logic        vector_take,
    input wire logic [12:0] vector_pc,
    input wire logic [12:0] resume_pc,
    input wire logic        wake_up
);
    typedef struct packed {
        logic        gen;
        logic [1:0]  qph;
        logic [12:0] pc_last;
        logic [12:0] pc_save;
    } mic_chk_t;
    mic_chk_t st_ff;
    mic_chk_t nxt_st;
    wire ctrl_wr = psel && penable && pwrite && paddr == mic_pkg::OFS_CTRL;

    always_comb begin
        nxt_st         = st_ff;
        nxt_st.qph     = st_ff.qph + 2'h1;
        nxt_st.pc_last = return_pc;
        if (vector_take) begin
            nxt_st.gen     = 1'b0;
            nxt_st.pc_save = st_ff.pc_last;
        end
        // a return beats a control write in the same cycle
        if (ctrl_wr)
            nxt_st.gen = pwdata[mic_pkg::B_GEN];
        if (ret_from_irq)
            nxt_st.gen = 1'b1;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    take_single_a: assert property (vector_take |=> !vector_take)
        else $error("take pulse longer than one cycle");
    vector_addr_a: assert property (vector_take |-> vector_pc == 13'h0004)
        else $error("vector address wrong at take");
    take_gated_a: assert property (vector_take |-> st_ff.gen)
        else $error("take while global enable clear");
    take_phase_a: assert property (vector_take |-> st_ff.qph == 2'h0)
        else $error("take off the instruction boundary");
    resume_pc_a: assert property (ret_from_irq |=> resume_pc == st_ff.pc_save)
        else $error("popped pc differs from pushed pc");
    wake_sleep_a: assert property (!$past(sleep_mode) |-> !wake_up)
        else $error("wake without sleep");
    err_unmap_a: assert property (psel && !penable && paddr == 12'hFFC |=> pslverr)
        else $error("unmapped access not flagged");
    err_mapped_a: assert property (psel && !penable && paddr == 12'h000 |=> !pslverr)
        else $error("mapped access flagged");
endmodule : mic_intc_chk

bind mic_intc mic_intc_chk i_chk (
    .clock, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr,
    .sleep_mode, .ret_from_irq, .return_pc, .vector_take, .vector_pc,
    .resume_pc, .wake_up
);

// file: testbench/testbench.sv
// Purpose: self-checking bench for the interrupt controller
// Assumes: core model answers takes and returns
// Notes: expected values follow the control bit layout
`timescale 1ns/100ps
module testbench;
    logic        clock, arst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        ext_irq_pin, timer_wrap, sleep_mode, ret_from_irq;
    logic [3:0]  port_b_pins;
    logic [8:0]  periph_evt;
    logic [12:0] return_pc, vector_pc, resume_pc, saved_pc;
    logic        vector_take, wake_up, irq_out, go_sleep, go_ret, last_err;
    int          n_mismatch, total_checks, n_take, k;

    mic_intc i_dut (
        .clock, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .ext_irq_pin, .port_b_pins,
        .timer_wrap, .periph_evt, .sleep_mode, .ret_from_irq, .return_pc,
        .vector_take, .vector_pc, .resume_pc, .wake_up, .irq_out
    );
    mic_core_model i_core (
        .clock, .arst_n, .go_sleep, .go_ret, .vector_take, .wake_up,
        .sleep_mode, .ret_from_irq, .return_pc, .saved_pc
    );

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        q = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // idle edge keeps a following setup off this time step
        @(posedge clock);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        check(q, exp);
    endtask : rd
    task automatic clk(input int n);
        repeat (n) @(posedge clock);
    endtask : clk
    task automatic wait_take();
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (vector_take !== 1'b1 && k < 40);
    endtask : wait_take
    task automatic ret();
        go_ret <= 1'b1;
        @(posedge clock);
        go_ret <= 1'b0;
        clk(3);
    endtask : ret

    always @(negedge clock)
        if (vector_take === 1'b1)
            n_take++;

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        repeat (3000) @(posedge clock);
        n_mismatch++;
        give_verdict();
    end
    initial begin
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        ext_irq_pin = 1'b0;
        port_b_pins = 4'h0;
        timer_wrap = 1'b0;
        periph_evt = 9'h000;
        go_sleep = 1'b0;
        go_ret = 1'b0;
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        rd(mic_pkg::OFS_CTRL, 32'h00);
        rd(mic_pkg::OFS_OPTION, 32'hFF);
        rd(12'hFFC, 32'h0);
        check(32'(last_err), 32'h1);
        // every source with all enables off
        ext_irq_pin <= 1'b1;
        timer_wrap  <= 1'b1;
        port_b_pins <= 4'h8;
        periph_evt  <= 9'h1FF;
        @(posedge clock);
        timer_wrap  <= 1'b0;
        periph_evt  <= 9'h000;
        clk(2);
        rd(mic_pkg::OFS_CTRL, 32'h07);
        rd(mic_pkg::OFS_PFLAG, 32'h1FF);
        rd(mic_pkg::OFS_CTRL, 32'h07);
        check(32'(n_take), 32'h0);
        wr(mic_pkg::OFS_CTRL, 32'h00);
        wr(mic_pkg::OFS_PFLAG, 32'h000);
        rd(mic_pkg::OFS_PFLAG, 32'h000);
        wr(mic_pkg::OFS_OPTION, 32'hBF);
        ext_irq_pin <= 1'b0;
        clk(2);
        rd(mic_pkg::OFS_CTRL, 32'h02);
        wr(mic_pkg::OFS_CTRL, 32'h00);
        ext_irq_pin <= 1'b1;
        clk(2);
        rd(mic_pkg::OFS_CTRL, 32'h00);
        wr(mic_pkg::OFS_OPTION, 32'hFF);
        ext_irq_pin <= 1'b0;
        clk(2);
        rd(mic_pkg::OFS_CTRL, 32'h00);
        wr(mic_pkg::OFS_STEN, 32'h1);
        wr(mic_pkg::OFS_CTRL, 32'h90);
        ext_irq_pin <= 1'b1;
        wait_take();
        // pin moves in the second clock of an instruction cycle,
        // so the take opens the third instruction cycle after it
        check(32'(k), 32'hC);
        check(32'(vector_pc), 32'h0004);
        clk(1);
        check(32'(irq_out), 32'h1);
        rd(mic_pkg::OFS_CTRL, 32'h12);
        wr(mic_pkg::OFS_CTRL, 32'h10);
        ret();
        check(32'(resume_pc), 32'(saved_pc));
        rd(mic_pkg::OFS_CTRL, 32'h90);
        rd(mic_pkg::OFS_STAT, 32'h5);
        wr(mic_pkg::OFS_STCLR, 32'h7);
        check(32'(irq_out), 32'h0);
        wr(mic_pkg::OFS_PEN, 32'h008);
        periph_evt <= 9'h008;
        @(posedge clock);
        periph_evt <= 9'h000;
        clk(40);
        check(32'(n_take), 32'h1);
        wr(mic_pkg::OFS_CTRL, 32'hC0);
        wait_take();
        check(32'(vector_take), 32'h1);
        ret();
        wait_take();
        check(32'(vector_take), 32'h1);
        wr(mic_pkg::OFS_PFLAG, 32'h000);
        ret();
        clk(40);
        check(32'(n_take), 32'h3);
        ext_irq_pin <= 1'b0;
        wr(mic_pkg::OFS_CTRL, 32'h10);
        go_sleep <= 1'b1;
        @(posedge clock);
        go_sleep <= 1'b0;
        ext_irq_pin <= 1'b1;
        k = 0;
        while (wake_up !== 1'b1 && k < 20) begin
            @(posedge clock);
            k++;
        end
        check(32'(wake_up), 32'h1);
        clk(40);
        check(32'(n_take), 32'h3);
        // control writes load the flags too, so keep the pin flag set
        wr(mic_pkg::OFS_CTRL, 32'h92);
        wait_take();
        check(32'(vector_take), 32'h1);
        for (int i = 0; i < 16; i += 15) begin
            wr(12'h100 + 12'(i * 4), 32'hA5 + 32'(i));
            rd(12'h1C0 + 12'(i * 4), 32'hA5 + 32'(i));
        end
        give_verdict();
    end
endmodule : testbench
